// ==== rtl/pcc_pkg.sv ====
// package for the clock configuration block: register map, fields, frequency windows
package pcc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REF = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CORE = 8'h18;
    localparam int DVF_W = 5;
    localparam int MLT_W = 8;
    localparam int SEL_W = 2;
    localparam int DVF_LSB = 0;
    localparam int MLT_LSB = 8;
    localparam int RNG_BIT = 16;
    localparam int SEL_LSB = 20;
    localparam int DDR_BIT = 24;
    localparam logic [DVF_W-1:0] DVF_RST = 5'h00;
    localparam logic [MLT_W-1:0] MLT_RST = 8'h1d;
    localparam logic [SEL_W-1:0] SEL_RST = 2'h1;
    localparam logic [SEL_W-1:0] SEL_DIV_HI = 2'h3;
    localparam logic [SEL_W-1:0] SEL_DIV_LO = 2'h1;
    // frequencies in kHz
    localparam logic [31:0] REF_RST_KHZ = 32'h00002710;
    localparam logic [31:0] REF_MIN_KHZ = 32'h00002710;
    localparam logic [31:0] REF_MAX_KHZ = 32'h000186a0;
    localparam logic [31:0] PRE_MIN_KHZ = 32'h00002904;
    localparam logic [31:0] PRE_MAX_KHZ = 32'h00004c2c;
    localparam logic [31:0] LOOP_MIN_KHZ = 32'h000493e0;
    localparam logic [31:0] LOOP_MAX_KHZ = 32'h000927c0;
    localparam logic [31:0] CORE2_MIN_KHZ = 32'h000249f0;
    localparam logic [31:0] CORE2_MAX_KHZ = 32'h00030d40;
    localparam logic [31:0] CORE4_MIN_KHZ = 32'h000124f8;
    localparam logic [31:0] CORE4_MAX_KHZ = 32'h000249f0;
    localparam logic [31:0] CORE_ABS_KHZ = 32'h00040f10;
    localparam logic [31:0] DDR_MIN2_KHZ = 32'h00028868;
    localparam logic [31:0] DDR_MAX2_KHZ = 32'h00040f10;
    localparam logic [4:0] DVF_MAX = 5'h08;
    localparam int ST_ERR = 0;
    localparam int ST_CHG = 1;
    localparam int ST_DONE = 2;
    localparam int NST = 3;
    typedef enum logic [1:0] {
        PCC_IDLE = 2'b00,
        PCC_DIV = 2'b01,
        PCC_CHK = 2'b10
    } pcc_state_type;
endpackage : pcc_pkg

// ==== rtl/pcc_divider.sv ====
// sequential divider: numerator over (den) with restoring steps
`timescale 1ns/1ps
module pcc_divider (
    input wire logic i_core_clk, // clock
    input wire logic i_rst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_start, // start pulse
    input wire logic [31:0] i_num, // numerator
    input wire logic [5:0] i_den, // divisor, nonzero
    output logic o_busy, // division running
    output logic [31:0] o_quot // quotient
);
    import pcc_pkg::*;
    typedef struct packed {
        logic busy;
        logic [5:0] cnt;
        logic [31:0] q;
        logic [31:0] r;
        logic [5:0] den;
    } pcc_div_type;
    pcc_div_type s_q, s_d;
    logic [32:0] trial;
    always_comb begin
        s_d = s_q;
        trial = {s_q.r, s_q.q[31]} - {27'h0, s_q.den};
        if (i_start && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = 6'h20;
            s_d.q = i_num;
            s_d.r = 32'h0;
            s_d.den = i_den;
        end else if (s_q.busy) begin
            if (!trial[32]) begin
                s_d.r = trial[31:0];
                s_d.q = {s_q.q[30:0], 1'b1};
            end else begin
                s_d.r = {s_q.r[30:0], s_q.q[31]};
                s_d.q = {s_q.q[30:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 6'h1;
            s_d.busy = (s_q.cnt != 6'h1);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
    assign o_busy = s_q.busy;
    assign o_quot = s_q.q;
endmodule : pcc_divider

// ==== rtl/pcc_irq.sv ====
// sticky event status with write-one-to-clear and mask
`timescale 1ns/1ps
module pcc_irq #(
    parameter int N = 3 // number of events
) (
    input wire logic i_core_clk, // clock
    input wire logic i_rst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic [N-1:0] i_evt, // event pulses
    input wire logic [N-1:0] i_clr, // write-one clear
    input wire logic i_mask_we, // mask write
    input wire logic [N-1:0] i_mask, // mask data
    output logic [N-1:0] o_stat, // sticky status
    output logic [N-1:0] o_mask, // mask
    output logic o_irq // interrupt level
);
    typedef struct packed {
        logic [N-1:0] st;
        logic [N-1:0] mk;
    } pcc_irq_type;
    pcc_irq_type s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (i_mask_we) begin
            s_d.mk = i_mask;
        end
        for (int k = 0; k < N; k++) begin
            // set beats clear in the same cycle
            s_d.st[k] = i_evt[k] | (s_q.st[k] & ~i_clr[k]);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end
    assign o_stat = s_q.st;
    assign o_mask = s_q.mk;
    assign o_irq = |(s_q.st & s_q.mk);
endmodule : pcc_irq

// ==== rtl/pcc_top.sv ====
// clock configuration block: control word, frequency model and window checks
// Contract
// - reference clock is pre-divided, then multiplied.
// - pre-divide ratio is field value plus one.
// - loop output is pre-divided times field plus one.
// - range bit zero halves the loop output.
// - select field picks the core clock divider.
// - select 11 with range 1 reserved.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pcc_top (
    input wire logic i_core_clk, // 125 MHz clock
    input wire logic i_rst, // sync reset, active high
    input wire logic i_ce, // clock enable
    input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [pcc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic [pcc_pkg::DVF_W-1:0] o_predivide_factor_field, // applied pre-divide code
    output logic [pcc_pkg::MLT_W-1:0] o_loop_multiply_factor_field, // applied multiply code
    output logic o_vco_range_bit, // applied range bit
    output logic [pcc_pkg::SEL_W-1:0] o_core_clock_source_select, // applied select
    output logic o_cfg_error, // configuration outside windows
    output logic o_irq // interrupt level
);
    import pcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [DVF_W-1:0] dvf;
        logic [MLT_W-1:0] mlt;
        logic vco_range_bit;
        logic [SEL_W-1:0] sel;
        logic ddr;
        logic [31:0] ref_khz;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pcc_state_type st;
        logic dirty;
        logic [31:0] pre_khz;
        logic [31:0] vco_khz;
        logic [31:0] core_khz;
        logic err;
        logic start;
        logic vco_ok;
    } pcc_top_type;
    pcc_top_type s_q, s_d;

    logic div_busy;
    logic [31:0] div_quot;
    logic [5:0] div_den;
    logic [31:0] div_num;
    logic [NST-1:0] evt, clr, stat, mask;
    logic clr_we, mask_we;
    logic wr_fire, rd_fire;
    logic [31:0] loop_khz;
    logic [31:0] cw;

    ////////////////////////////////////////////////////////////////////////////
    // divider shared between the pre-divider and the core divide
    // start is seen one state late, so operands follow the check state
    // core divide factors apply to the loop output, not to the halved vco
    assign div_num = (s_q.st == PCC_CHK) ? loop_khz : s_q.ref_khz;
    always_comb begin
        div_den = {1'b0, s_q.dvf} + 6'h1;
        if (s_q.st == PCC_CHK) begin
            // 11 with range 0 and 01 with range 1 divide by two, 01 range 0 by four
            div_den = (s_q.sel == SEL_DIV_LO && !s_q.vco_range_bit) ? 6'h4 : 6'h2;
        end
    end
    pcc_divider u_div (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_start(s_q.start),
        .i_num(div_num),
        .i_den(div_den),
        .o_busy(div_busy),
        .o_quot(div_quot)
    );
    // loop frequency uses saturating product so odd codes cannot wrap
    logic [40:0] loop_prod;
    assign loop_prod = s_q.pre_khz * ({1'b0, s_q.mlt} + 9'h1);
    assign loop_khz = (|loop_prod[40:32]) ? 32'hffffffff : loop_prod[31:0];

    assign cw = {7'h0, s_q.ddr, 1'b0, 1'b0, s_q.sel, 3'h0, s_q.vco_range_bit, s_q.mlt, 3'h0, s_q.dvf};

    ////////////////////////////////////////////////////////////////////////////
    assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign rd_fire = s_axi_arvalid && !s_q.rvalid;
    assign clr_we = wr_fire && (s_q.awaddr == OFS_IRQ);
    assign mask_we = wr_fire && (s_q.awaddr == OFS_MASK);
    assign clr = clr_we ? s_q.wdata[NST-1:0] : '0;

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        evt = '0;
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = 2'b00;
            case (s_q.awaddr)
                OFS_CTRL: begin
                    if (s_q.wstrb[0]) begin
                        s_d.dvf = s_q.wdata[DVF_LSB +: DVF_W];
                    end
                    if (s_q.wstrb[1]) begin
                        s_d.mlt = s_q.wdata[MLT_LSB +: MLT_W];
                    end
                    if (s_q.wstrb[2]) begin
                        s_d.vco_range_bit = s_q.wdata[RNG_BIT];
                        s_d.sel = s_q.wdata[SEL_LSB +: SEL_W];
                    end
                    if (s_q.wstrb[3]) begin
                        s_d.ddr = s_q.wdata[DDR_BIT];
                    end
                    s_d.dirty = 1'b1;
                end
                OFS_REF: begin
                    if (&s_q.wstrb) begin
                        s_d.ref_khz = s_q.wdata;
                        s_d.dirty = 1'b1;
                    end
                end
                OFS_IRQ, OFS_MASK: begin
                end
                default: begin
                    s_d.bresp = 2'b10;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = 2'b00;
            case (s_axi_araddr)
                OFS_CTRL: s_d.rdata = cw;
                OFS_REF: s_d.rdata = s_q.ref_khz;
                OFS_STAT: s_d.rdata = {29'h0, s_q.st != PCC_IDLE, s_q.dirty, s_q.err};
                OFS_IRQ: s_d.rdata = {29'h0, stat};
                OFS_MASK: s_d.rdata = {29'h0, mask};
                OFS_FREQ: s_d.rdata = s_q.vco_khz;
                OFS_CORE: s_d.rdata = s_q.core_khz;
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = 2'b10;
                end
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // recompute frequencies after every change; checks run on fresh values
        case (s_q.st)
            PCC_IDLE: begin
                if (s_q.dirty && !div_busy) begin
                    s_d.dirty = 1'b0;
                    s_d.start = 1'b1;
                    s_d.st = PCC_DIV;
                    evt[ST_CHG] = 1'b1;
                end
            end
            PCC_DIV: begin
                if (!div_busy && !s_q.start) begin
                    s_d.pre_khz = div_quot;
                    s_d.st = PCC_CHK;
                end
            end
            PCC_CHK: begin
                // own flag: a zero loop rate must not relaunch the divide forever
                if (!s_q.start && !s_q.vco_ok) begin
                    s_d.vco_khz = s_q.vco_range_bit ? loop_khz : {1'b0, loop_khz[31:1]};
                    s_d.vco_ok = 1'b1;
                    s_d.start = 1'b1;
                end else if (!s_q.start && !div_busy) begin
                    s_d.core_khz = div_quot;
                    s_d.err = (s_q.ref_khz < REF_MIN_KHZ) || (s_q.ref_khz > REF_MAX_KHZ)
                        || (s_q.dvf > DVF_MAX)
                        || (s_q.pre_khz < PRE_MIN_KHZ) || (s_q.pre_khz > PRE_MAX_KHZ)
                        || (loop_khz < LOOP_MIN_KHZ) || (loop_khz > LOOP_MAX_KHZ)
                        || (s_q.sel == SEL_DIV_HI && s_q.vco_range_bit)
                        || (s_q.sel != SEL_DIV_HI && s_q.sel != SEL_DIV_LO)
                        || ((s_q.sel == SEL_DIV_LO && !s_q.vco_range_bit)
                            ? (div_quot < CORE4_MIN_KHZ || div_quot > CORE4_MAX_KHZ)
                            : (div_quot < CORE2_MIN_KHZ || div_quot > CORE2_MAX_KHZ))
                        || (div_quot > CORE_ABS_KHZ)
                        || (s_q.ddr && (div_quot < DDR_MIN2_KHZ
                            || div_quot > DDR_MAX2_KHZ));
                    evt[ST_DONE] = 1'b1;
                    s_d.st = PCC_IDLE;
                end
            end
            default: s_d.st = PCC_IDLE;
        endcase
        if (s_q.st == PCC_DIV && s_d.st == PCC_CHK) begin
            s_d.vco_khz = 32'h0;
            s_d.vco_ok = 1'b0;
        end
        if (s_q.st == PCC_CHK && s_d.st == PCC_IDLE && s_d.err) begin
            evt[ST_ERR] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.dvf <= DVF_RST;
            s_q.mlt <= MLT_RST;
            s_q.vco_range_bit <= 1'b1;
            s_q.sel <= SEL_RST;
            s_q.ref_khz <= REF_RST_KHZ;
            s_q.dirty <= 1'b1;
            s_q.st <= PCC_IDLE;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    pcc_irq #(
        .N(NST)
    ) u_irq (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_evt(evt),
        .i_clr(clr),
        .i_mask_we(mask_we),
        .i_mask(s_q.wdata[NST-1:0]),
        .o_stat(stat),
        .o_mask(mask),
        .o_irq(o_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign o_predivide_factor_field = s_q.dvf;
    assign o_loop_multiply_factor_field = s_q.mlt;
    assign o_vco_range_bit = s_q.vco_range_bit;
    assign o_core_clock_source_select = s_q.sel;
    assign o_cfg_error = s_q.err;

    ////////////////////////////////////////////////////////////////////////////
    AST_RSVD_ERR: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.st == PCC_CHK && s_d.st == PCC_IDLE && s_q.sel == SEL_DIV_HI && s_q.vco_range_bit && i_ce)
        |=> o_cfg_error) else $error("reserved select not flagged");
    AST_ERR_IRQ: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_ce && evt[ST_ERR]) |=> stat[ST_ERR]) else $error("error event not latched");
    AST_DEN: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.st != PCC_CHK) |-> (div_den == {1'b0, s_q.dvf} + 6'h1))
        else $error("pre-divide ratio wrong");
    // vco is loaded once per check pass, on its first free cycle
    sequence seq_vco_load;
        i_ce && s_q.st == PCC_CHK && !s_q.start && !s_q.vco_ok;
    endsequence
    // core divide is launched from the check state
    sequence seq_core_start;
        i_ce && s_q.st == PCC_CHK && s_q.start;
    endsequence
    AST_RANGE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (seq_vco_load ##0 !s_q.vco_range_bit) |=> (s_q.vco_khz == $past(loop_khz) >> 1))
        else $error("range halving wrong");
    AST_RANGE_ONE: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (seq_vco_load ##0 s_q.vco_range_bit) |=> (s_q.vco_khz == $past(loop_khz)))
        else $error("range one not passed through");
    AST_CORE_DIV: assert property (@(posedge i_core_clk) disable iff (i_rst)
        seq_core_start |-> (div_num == loop_khz
            && div_den == ((s_q.sel == SEL_DIV_LO && !s_q.vco_range_bit) ? 6'h4 : 6'h2)))
        else $error("core divide setup wrong");
endmodule : pcc_top

// ==== test/pll_core_clock_config_tb_top.sv ====
// self-checking testbench for the clock configuration block
`timescale 1ns/1ps
module pll_core_clock_config_tb_top;
    import pcc_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} pcc_rnote_type;
    typedef struct packed {logic [1:0] r; logic c;} pcc_wnote_type;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, o_vco_range_bit, o_cfg_error, o_irq;
    logic [1:0] bresp, rresp, o_core_clock_source_select;
    logic [31:0] rdata, rd_val;
    logic [4:0] o_predivide_factor_field;
    logic [7:0] o_loop_multiply_factor_field;
    pcc_rnote_type rq[$];
    pcc_wnote_type wq[$];
    pcc_rnote_type rn;
    pcc_wnote_type wn;
    int num_errors = 0;
    int checks = 0;
    bit frz = 1'b0;

    pcc_top DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .o_predivide_factor_field(o_predivide_factor_field),
        .o_loop_multiply_factor_field(o_loop_multiply_factor_field),
        .o_vco_range_bit(o_vco_range_bit),
        .o_core_clock_source_select(o_core_clock_source_select),
        .o_cfg_error(o_cfg_error), .o_irq(o_irq));

    always #4 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // monitor: every response takes the oldest note of its channel
    always @(posedge i_core_clk) begin
        if (rvalid && rready && rq.size() > 0) begin
            rn = rq.pop_front();
            if (rn.m != 32'h0) cmp(rdata & rn.m, rn.d & rn.m);
            cmp({30'h0, rresp}, {30'h0, rn.r});
        end
        if (bvalid && bready && wq.size() > 0) begin
            wn = wq.pop_front();
            if (wn.c) cmp({30'h0, bresp}, {30'h0, wn.r});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r, input logic c);
        wq.push_back('{r, c});
        @(posedge i_core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] r);
        rq.push_back('{e, m, r});
        @(posedge i_core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rd_val = rdata;
        rready <= 1'b0;
    endtask : rd

    // reference arithmetic in kHz; core divide is taken from the loop output
    function automatic void model(input logic [31:0] rf, input logic [4:0] dv,
        input logic [7:0] mt, input logic rg, input logic [1:0] sl, input logic dd,
        output logic [31:0] vco, output logic [31:0] core, output logic err);
        logic [31:0] pre, loop;
        logic f4;
        pre = rf / (dv + 32'h1);
        loop = pre * (mt + 32'h1);
        vco = rg ? loop : loop >> 1;
        f4 = (sl != 2'h3) && !rg;
        core = f4 ? loop >> 2 : loop >> 1;
        err = rf < REF_MIN_KHZ || rf > REF_MAX_KHZ || dv > DVF_MAX || pre < PRE_MIN_KHZ
            || pre > PRE_MAX_KHZ || loop < LOOP_MIN_KHZ || loop > LOOP_MAX_KHZ || !sl[0]
            || (sl == 2'h3 && rg) || core > CORE_ABS_KHZ
            || (f4 ? (core < CORE4_MIN_KHZ || core > CORE4_MAX_KHZ)
                   : (core < CORE2_MIN_KHZ || core > CORE2_MAX_KHZ))
            || (dd && (core < DDR_MIN2_KHZ || core > DDR_MAX2_KHZ));
    endfunction : model

    task automatic cfg(input logic [31:0] rf, input logic [4:0] dv, input logic [7:0] mt,
                       input logic rg, input logic [1:0] sl, input logic dd);
        logic [31:0] vco, core, cw;
        logic err;
        int n;
        model(rf, dv, mt, rg, sl, dd, vco, core, err);
        cw = {7'h0, dd, 2'h0, sl, 3'h0, rg, mt, 3'h0, dv};
        wr(OFS_REF, rf, 4'hf, 2'h0, 1'b1);
        wr(OFS_CTRL, cw, 4'hf, 2'h0, 1'b1);
        if (frz) begin
            i_ce <= 1'b0;
            repeat (20) @(posedge i_core_clk);
            i_ce <= 1'b1;
        end
        n = 0;
        do begin
            rd(OFS_STAT, 32'h0, 32'h0, 2'h0);
            n++;
        end while (rd_val[2:1] != 2'h0 && n < 300);
        cmp({30'h0, rd_val[2:1]}, 32'h0);
        rd(OFS_STAT, {31'h0, err}, 32'h7, 2'h0);
        rd(OFS_FREQ, vco, 32'hffffffff, 2'h0);
        if (sl == 2'h1 || (sl == 2'h3 && !rg)) rd(OFS_CORE, core, 32'hffffffff, 2'h0);
        cmp({31'h0, o_cfg_error}, {31'h0, err});
        cmp({o_core_clock_source_select, o_vco_range_bit, o_loop_multiply_factor_field,
             o_predivide_factor_field}, {sl, rg, mt, dv});
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    initial begin
        logic [31:0] pre;
        logic [4:0] dv;
        void'($urandom(40));
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(OFS_CTRL, 32'h00111d00, 32'hffffffff, 2'h0);
        rd(OFS_REF, REF_RST_KHZ, 32'hffffffff, 2'h0);
        cfg(REF_RST_KHZ, DVF_RST, MLT_RST, 1'b1, SEL_RST, 1'b0);
        wr(OFS_MASK, 32'h0, 4'hf, 2'h0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        cmp({31'h0, o_irq}, 32'h0);
        wr(OFS_MASK, 32'h4, 4'hf, 2'h0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        cmp({31'h0, o_irq}, 32'h1);
        wr(OFS_IRQ, 32'h7, 4'hf, 2'h0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        cmp({31'h0, o_irq}, 32'h0);
        rd(OFS_IRQ, 32'h0, 32'h7, 2'h0);
        wr(OFS_MASK, 32'h1, 4'hf, 2'h0, 1'b1);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h1, 1'b0);
        // the first pass mixes old and new fields and may flag an error
        wr(OFS_IRQ, 32'h7, 4'hf, 2'h0, 1'b1);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h1, 1'b0);
        cmp({31'h0, o_irq}, 32'h0);
        frz = 1'b1;
        cfg(32'h7530, 5'h01, 8'h17, 1'b0, 2'h1, 1'b0);
        frz = 1'b0;
        cfg(32'h7530, 5'h01, 8'h17, 1'b0, 2'h3, 1'b0);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h3, 1'b0);
        cmp({31'h0, o_irq}, 32'h1);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h0, 1'b0);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h2, 1'b0);
        cfg(32'h7530, 5'h00, 8'h17, 1'b1, 2'h1, 1'b0);
        cfg(32'h7530, 5'h01, 8'h31, 1'b1, 2'h1, 1'b0);
        cfg(32'h7530, 5'h01, 8'h17, 1'b0, 2'h1, 1'b1);
        cfg(32'h7530, 5'h01, 8'h17, 1'b1, 2'h1, 1'b1);
        cfg(32'h1d4c0, 5'h08, 8'h1d, 1'b1, 2'h1, 1'b0);
        cfg(32'h182b8, 5'h08, 8'h1d, 1'b1, 2'h1, 1'b0);
        // partial strobes must leave the reference rate alone
        wr(OFS_REF, 32'h00007530, 4'h3, 2'h0, 1'b0);
        rd(OFS_REF, 32'h000182b8, 32'hffffffff, 2'h0);
        wr(8'h1c, 32'h0, 4'hf, 2'h2, 1'b1);
        rd(8'h1c, 32'h0, 32'hffffffff, 2'h2);
        wr(OFS_IRQ, 32'h7, 4'hf, 2'h0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        cmp({31'h0, o_irq}, 32'h0);
        repeat (20) begin
            dv = 5'($urandom % 9);
            pre = 32'h2710 + 32'($urandom % 10000);
            cfg(pre * (dv + 32'h1), dv, 8'($urandom), 1'($urandom), 2'($urandom),
                1'($urandom));
        end
        final_report();
    end
endmodule : pll_core_clock_config_tb_top
